// ---- hw/frame_fifo.v ----
// flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module frame_fifo #(
  parameter WIDTH = 96,
  parameter DEPTH = 32
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge core_clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- hw/time_base.v ----
// 100 us and 1 ms tick generator from the core clock
`timescale 1ns/100ps
`default_nettype none
module time_base #(
  parameter TICK_CYCLES = 1000,
  parameter MS_TICKS = 10
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // ticks
  output reg tick_100us_o,
  output reg tick_1ms_o
);
  reg [15:0] cyc_q;
  reg [7:0] sub_q;
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cyc_q <= 16'h0000;
      sub_q <= 8'h00;
      tick_100us_o <= 1'b0;
      tick_1ms_o <= 1'b0;
    end
    else
    begin
      tick_100us_o <= 1'b0;
      tick_1ms_o <= 1'b0;
      if (cyc_q == TICK_CYCLES[15:0] - 16'h0001)
      begin
        cyc_q <= 16'h0000;
        tick_100us_o <= 1'b1;
        if (sub_q == MS_TICKS[7:0] - 8'h01)
        begin
          sub_q <= 8'h00;
          tick_1ms_o <= 1'b1;
        end
        else
          sub_q <= sub_q + 8'h01;
      end
      else
        cyc_q <= cyc_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- hw/tx_pdo_comm_param_scheduler.v ----
// transmit channel parameter records and send scheduler
`timescale 1ns/100ps
`include "tx_pdo_defs.vh"
`default_nettype none
module tx_pdo_comm_param_scheduler #(
  parameter DATA_W = 64,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire core_clk_i,
  input wire arst_n_i,
  // object dictionary access
  input wire od_req_i,
  input wire od_wr_i,
  input wire [15:0] od_index_i,
  input wire [7:0] od_sub_i,
  input wire [31:0] od_wdata_i,
  output reg od_ack_o,
  output reg od_abort_o,
  output reg [31:0] od_rdata_o,
  // store and restart
  input wire save_req_i,
  input wire restart_i,
  // sync and events
  input wire sync_i,
  input wire [7:0] sync_count_i,
  input wire [7:0] sync_overflow_i,
  input wire [1:0] app_event_i,
  // mapped data per channel
  input wire [DATA_W-1:0] tx2_map_data_i,
  input wire [DATA_W-1:0] tx3_map_data_i,
  // outgoing frames
  output reg frame_valid_o,
  input wire frame_ready_i,
  output reg [31:0] frame_id_o,
  output reg [DATA_W-1:0] frame_data_o
);
  localparam FW = 32 + DATA_W;
  localparam [31:0] INH_STEP = `TICK_CYCLES;
  integer i, j, k;
  reg [1:0] rst_q;
  wire rst_n;
  wire tick_1ms;
  // live and saved records, index 0 is the second channel
  reg [31:0] id_q [0:1];
  reg [7:0] trig_q [0:1];
  reg [15:0] inh_q [0:1];
  reg [7:0] place_q [0:1];
  reg [15:0] etmr_q [0:1];
  reg [7:0] sstart_q [0:1];
  reg [87:0] sv_rec_q [0:1];
  // scheduler state
  reg [1:0] started_q;
  reg [7:0] div_q [0:1];
  reg [31:0] inh_cnt_q [0:1];
  reg [15:0] etmr_cnt_q [0:1];
  reg [1:0] pend_async_q;
  reg [1:0] pend_sync_q;
  reg [1:0] acyc_q;
  reg [1:0] sync_due;
  reg [1:0] tmr_fire;
  reg [1:0] can_send;
  reg [1:0] grant;
  reg start_hit;
  reg grant_ch;
  reg [FW-1:0] push_data;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [FW-1:0] fifo_out_data;
  wire od_hit;
  wire od_ch;
  function is_async;
    input [7:0] tt;
    begin
      is_async = (tt >= `TRIG_ASYNC_MIN);
    end
  endfunction
  function is_sync;
    input [7:0] tt;
    begin
      is_sync = (tt <= `TRIG_SYNC_MAX);
    end
  endfunction
  // reset release through two flip-flops
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];
  time_base #(
    .TICK_CYCLES(`TICK_CYCLES),
    .MS_TICKS(`MS_TICKS)
  ) u_time_base (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .tick_100us_o(),
    .tick_1ms_o(tick_1ms)
  );
  assign od_hit = (od_index_i == `REC_IDX_TX2) ||
                  (od_index_i == `REC_IDX_TX3);
  assign od_ch = (od_index_i == `REC_IDX_TX3);
  // record storage, access answers one cycle after a request
  always @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        id_q[i] <= `RST_IDENT;
        trig_q[i] <= `RST_TRIG;
        inh_q[i] <= `RST_INHIBIT;
        place_q[i] <= `RST_PLACE;
        etmr_q[i] <= `RST_EVT_TMR;
        sstart_q[i] <= `RST_SYNC_START;
        sv_rec_q[i] <= {`RST_IDENT, `RST_TRIG, `RST_INHIBIT, `RST_PLACE,
                        `RST_EVT_TMR, `RST_SYNC_START};
      end
      od_ack_o <= 1'b0;
      od_abort_o <= 1'b0;
      od_rdata_o <= 32'h00000000;
    end
    else
    begin
      od_ack_o <= od_req_i;
      od_abort_o <= 1'b0;
      od_rdata_o <= 32'h00000000;
      if (save_req_i)
        for (i = 0; i < 2; i = i + 1)
          sv_rec_q[i] <= {id_q[i], trig_q[i], inh_q[i], place_q[i],
                          etmr_q[i], sstart_q[i]};
      if (restart_i)
        for (i = 0; i < 2; i = i + 1)
          {id_q[i], trig_q[i], inh_q[i], place_q[i], etmr_q[i],
           sstart_q[i]} <= sv_rec_q[i];
      else if (od_req_i)
      begin
        if (od_index_i == `REC_IDX_TX4 && od_sub_i == `SUB_COUNT)
        begin
          od_rdata_o <= {24'h000000, `ENTRY_COUNT};
          od_abort_o <= od_wr_i;
        end
        else if (!od_hit)
          od_abort_o <= 1'b1;
        else
          case (od_sub_i)
            `SUB_COUNT:
            begin
              od_rdata_o <= {24'h000000, `ENTRY_COUNT};
              od_abort_o <= od_wr_i;
            end
            `SUB_IDENT:
            begin
              if (od_wr_i)
                id_q[od_ch] <= od_wdata_i;
              od_rdata_o <= id_q[od_ch];
            end
            `SUB_TRIG:
            begin
              if (od_wr_i)
                trig_q[od_ch] <= od_wdata_i[7:0];
              od_rdata_o <= {24'h000000, trig_q[od_ch]};
            end
            `SUB_INHIBIT:
            begin
              if (od_wr_i)
                inh_q[od_ch] <= od_wdata_i[15:0];
              od_rdata_o <= {16'h0000, inh_q[od_ch]};
            end
            `SUB_PLACE:
            begin
              if (od_wr_i)
                place_q[od_ch] <= od_wdata_i[7:0];
              od_rdata_o <= {24'h000000, place_q[od_ch]};
            end
            `SUB_EVT_TMR:
            begin
              if (od_wr_i)
                etmr_q[od_ch] <= od_wdata_i[15:0];
              od_rdata_o <= {16'h0000, etmr_q[od_ch]};
            end
            `SUB_SYNC_START:
            begin
              if (od_wr_i)
                sstart_q[od_ch] <= od_wdata_i[7:0];
              od_rdata_o <= {24'h000000, sstart_q[od_ch]};
            end
            default:
              od_abort_o <= 1'b1;
          endcase
      end
    end
  end
  // per channel send decisions
  always @*
  begin
    sync_due = 2'b00;
    tmr_fire = 2'b00;
    can_send = 2'b00;
    start_hit = 1'b0;
    for (j = 0; j < 2; j = j + 1)
    begin
      start_hit = started_q[j] || sstart_q[j] == 8'h00 ||
                  sync_overflow_i <= `SYNC_OVF_MIN ||
                  sync_count_i == sstart_q[j];
      if (sync_i && start_hit && is_sync(trig_q[j]))
      begin
        if (trig_q[j] == 8'h00)
          sync_due[j] = acyc_q[j] | app_event_i[j];
        else
          sync_due[j] = (div_q[j] + 8'h01 >= trig_q[j]);
      end
      tmr_fire[j] = tick_1ms && etmr_q[j] != 16'h0000 &&
                    is_async(trig_q[j]) &&
                    etmr_cnt_q[j] + 16'h0001 >= etmr_q[j];
      can_send[j] = pend_sync_q[j] ||
                    (pend_async_q[j] && inh_cnt_q[j] == 32'h00000000);
    end
    grant = 2'b00;
    grant_ch = 1'b0;
    if (fifo_in_ready && !restart_i)
    begin
      if (can_send[0])
        grant[0] = 1'b1;
      else if (can_send[1])
      begin
        grant[1] = 1'b1;
        grant_ch = 1'b1;
      end
    end
    push_data = grant_ch ? {id_q[1], tx3_map_data_i} :
                           {id_q[0], tx2_map_data_i};
  end
  // scheduler state
  always @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      started_q <= 2'b00;
      pend_async_q <= 2'b00;
      pend_sync_q <= 2'b00;
      acyc_q <= 2'b00;
      for (k = 0; k < 2; k = k + 1)
      begin
        div_q[k] <= 8'h00;
        inh_cnt_q[k] <= 32'h00000000;
        etmr_cnt_q[k] <= 16'h0000;
      end
    end
    else if (restart_i)
    begin
      started_q <= 2'b00;
      pend_async_q <= 2'b00;
      pend_sync_q <= 2'b00;
      acyc_q <= 2'b00;
      for (k = 0; k < 2; k = k + 1)
      begin
        div_q[k] <= 8'h00;
        inh_cnt_q[k] <= 32'h00000000;
        etmr_cnt_q[k] <= 16'h0000;
      end
    end
    else
      for (k = 0; k < 2; k = k + 1)
      begin
        if (sync_due[k])
          started_q[k] <= 1'b1;
        if (sync_i && is_sync(trig_q[k]) && trig_q[k] != 8'h00 &&
            (started_q[k] || sync_due[k] || div_q[k] != 8'h00 ||
             sstart_q[k] == 8'h00 || sync_overflow_i <= `SYNC_OVF_MIN ||
             sync_count_i == sstart_q[k]))
          div_q[k] <= sync_due[k] ? 8'h00 : div_q[k] + 8'h01;
        // acyclic request is consumed by the sync that sends it
        if (sync_due[k] && trig_q[k] == 8'h00)
          acyc_q[k] <= 1'b0;
        else if (app_event_i[k] && trig_q[k] == 8'h00)
          acyc_q[k] <= 1'b1;
        if (etmr_q[k] == 16'h0000 || !is_async(trig_q[k]))
          etmr_cnt_q[k] <= 16'h0000;
        else if (tmr_fire[k])
          etmr_cnt_q[k] <= 16'h0000;
        else if (tick_1ms)
          etmr_cnt_q[k] <= etmr_cnt_q[k] + 16'h0001;
        // pending flags, new request wins over clear
        if ((app_event_i[k] && is_async(trig_q[k])) || tmr_fire[k])
          pend_async_q[k] <= 1'b1;
        else if (grant[k])
          pend_async_q[k] <= 1'b0;
        if (sync_due[k])
          pend_sync_q[k] <= 1'b1;
        else if (grant[k])
          pend_sync_q[k] <= 1'b0;
        // inhibit in cycles, counted from the grant
        if (grant[k] && !pend_sync_q[k] && is_async(trig_q[k]))
          inh_cnt_q[k] <= {16'h0000, inh_q[k]} * INH_STEP;
        else if (inh_cnt_q[k] != 32'h00000000)
          inh_cnt_q[k] <= inh_cnt_q[k] - 32'h00000001;
      end
  end
  frame_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_frame_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(grant[0] | grant[1]),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );
  assign fifo_out_ready = ~frame_valid_o | frame_ready_i;
  // registered frame output stage
  always @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_valid_o <= 1'b0;
      frame_id_o <= 32'h00000000;
      frame_data_o <= {DATA_W{1'b0}};
    end
    else if (fifo_out_ready)
    begin
      frame_valid_o <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        frame_id_o <= fifo_out_data[FW-1:DATA_W];
        frame_data_o <= fifo_out_data[DATA_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/tx_pdo_defs.vh ----
// constants for the transmit channel parameter scheduler
`ifndef TX_PDO_DEFS_VH
`define TX_PDO_DEFS_VH
`define REC_IDX_TX2 16'h1801
`define REC_IDX_TX3 16'h1802
`define REC_IDX_TX4 16'h1803
`define SUB_COUNT 8'h00
`define SUB_IDENT 8'h01
`define SUB_TRIG 8'h02
`define SUB_INHIBIT 8'h03
`define SUB_PLACE 8'h04
`define SUB_EVT_TMR 8'h05
`define SUB_SYNC_START 8'h06
`define ENTRY_COUNT 8'h06
`define RST_IDENT 32'h00000000
`define RST_TRIG 8'hFF
`define RST_INHIBIT 16'h0064
`define RST_PLACE 8'h00
`define RST_EVT_TMR 16'h0000
`define RST_SYNC_START 8'h00
`define TRIG_SYNC_MAX 8'hF0
`define TRIG_ASYNC_MIN 8'hFE
`define SYNC_OVF_MIN 8'h01
`define CLK_MHZ 10
`define TICK_US 100
`define MS_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define MS_TICKS (`MS_US / `TICK_US)
`define FIFO_DEPTH 32
`endif

// ---- sim/net_master_model.sv ----
// network master model taking frames from the scheduler
`timescale 1ns/100ps
`default_nettype none
module net_master_model #(
  parameter DATA_W = 64
) (
  // clock
  input wire logic core_clk_i,
  // frames in
  input wire logic valid_i,
  input wire logic [31:0] id_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic ready_o,
  // control and record
  input wire logic stall_i,
  output logic [31:0] got_n,
  output logic [31:0] got_id,
  output logic [DATA_W-1:0] got_data
);
  initial got_n = 32'h00000000;
  assign ready_o = !stall_i;
  always @(posedge core_clk_i)
  begin
    if (valid_i && ready_o)
    begin
      got_n <= got_n + 32'h00000001;
      got_id <= id_i;
      got_data <= data_i;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tx_pdo_comm_param_scheduler_tb.sv ----
// self-checking bench for the transmit channel parameter scheduler
`timescale 1ns/100ps
`include "tx_pdo_defs.vh"
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_fail++; $display("ERROR %0t: got %h want %h", $time, (a), (b)); \
  end end
module tx_pdo_comm_param_scheduler_tb;
  logic core_clk_i = 1'b0, arst_n_i = 1'b0, od_req_i = 1'b0, od_wr_i = 1'b0;
  logic save_req_i = 1'b0, restart_i = 1'b0, sync_i = 1'b0, stall = 1'b0;
  logic [15:0] od_index_i = 16'h0000;
  logic [7:0] od_sub_i = 8'h00, sync_count_i = 8'h00, sync_overflow_i = 8'h01;
  logic [31:0] od_wdata_i = 32'h00000000, rd, n0;
  logic [1:0] app_event_i = 2'h0;
  logic [63:0] map2 = 64'h1122334455667788, map3 = 64'h0F0E0D0C0B0A0908;
  logic [31:0] dv [7] = '{{24'h0, `ENTRY_COUNT}, `RST_IDENT,
    {24'h0, `RST_TRIG}, {16'h0, `RST_INHIBIT}, {24'h0, `RST_PLACE},
    {16'h0, `RST_EVT_TMR}, {24'h0, `RST_SYNC_START}};
  logic ab, ak;
  wire od_ack_o, od_abort_o, frame_valid_o, frame_ready_i;
  wire [31:0] od_rdata_o, frame_id_o, got_n, got_id;
  wire [63:0] frame_data_o, got_data;
  int n_fail = 0, samples_checked = 0;
  always #50 core_clk_i = ~core_clk_i;
  tx_pdo_comm_param_scheduler #(.DATA_W(64), .FIFO_DEPTH(`FIFO_DEPTH)) dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .od_req_i(od_req_i),
    .od_wr_i(od_wr_i), .od_index_i(od_index_i), .od_sub_i(od_sub_i),
    .od_wdata_i(od_wdata_i), .od_ack_o(od_ack_o), .od_abort_o(od_abort_o),
    .od_rdata_o(od_rdata_o), .save_req_i(save_req_i), .restart_i(restart_i),
    .sync_i(sync_i), .sync_count_i(sync_count_i),
    .sync_overflow_i(sync_overflow_i), .app_event_i(app_event_i),
    .tx2_map_data_i(map2), .tx3_map_data_i(map3),
    .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i),
    .frame_id_o(frame_id_o), .frame_data_o(frame_data_o));
  net_master_model #(.DATA_W(64)) master (
    .core_clk_i(core_clk_i), .valid_i(frame_valid_o), .id_i(frame_id_o),
    .data_i(frame_data_o), .ready_o(frame_ready_i), .stall_i(stall),
    .got_n(got_n), .got_id(got_id), .got_data(got_data));
  task automatic od(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd);
    @(negedge core_clk_i);
    od_req_i = 1'b1;
    od_wr_i = wr;
    od_index_i = idx;
    od_sub_i = sub;
    od_wdata_i = wd;
    @(negedge core_clk_i);
    od_req_i = 1'b0;
    rd = od_rdata_o;
    ab = od_abort_o;
    ak = od_ack_o;
  endtask
  task automatic ev(input logic [1:0] m, input logic s, input logic [7:0] c);
    @(negedge core_clk_i);
    app_event_i = m;
    sync_i = s;
    sync_count_i = c;
    @(negedge core_clk_i);
    app_event_i = 2'h0;
    sync_i = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
  endtask
  task automatic wait_n(input logic [31:0] n, input int lim);
    for (int k = 0; k < lim && got_n < n; k++)
      @(negedge core_clk_i);
  endtask
  task automatic s_defaults;
    for (int c = 0; c < 3; c++)
      for (int s = 0; s < 7; s++)
      begin
        od(1'b0, 16'h1801 + c[15:0], s[7:0], 32'h00000000);
        if (c < 2 || s == 0)
          `CHK(rd, dv[s])
        `CHK(ab, (c == 2 && s != 0))
      end
  endtask
  task automatic s_access;
    od(1'b1, 16'h1801, 8'h00, 32'h00000012);
    `CHK(ab, 1'b1)
    od(1'b0, 16'h1801, 8'h00, 32'h00000000);
    `CHK(rd, 32'h00000006)
    `CHK(ak, 1'b1)
    od(1'b1, 16'h1802, 8'h01, 32'hA5A55A5A);
    od(1'b0, 16'h1802, 8'h01, 32'h00000000);
    `CHK(rd, 32'hA5A55A5A)
    od(1'b1, 16'h1801, 8'h04, 32'h0000003C);
    od(1'b0, 16'h1801, 8'h04, 32'h00000000);
    `CHK(rd, 32'h0000003C)
    od(1'b0, 16'h1801, 8'h07, 32'h00000000);
    `CHK(ab, 1'b1)
  endtask
  task automatic s_inhibit;
    od(1'b1, 16'h1801, 8'h01, 32'h00000181);
    od(1'b1, 16'h1801, 8'h03, 32'h00000001);
    n0 = got_n;
    ev(2'h1, 1'b0, 8'h00);
    wait_n(n0 + 1, 20);
    `CHK(got_id, 32'h00000181)
    `CHK(got_data, map2)
    ev(2'h1, 1'b0, 8'h00);
    wait_n(n0 + 2, 900);
    `CHK(got_n, n0 + 1)
    wait_n(n0 + 2, 200);
    `CHK(got_n, n0 + 2)
  endtask
  task automatic s_timer;
    od(1'b1, 16'h1801, 8'h03, 32'h00000000);
    od(1'b1, 16'h1801, 8'h05, 32'h00000001);
    n0 = got_n;
    wait_n(n0 + 1, 12000);
    `CHK(got_n, n0 + 1)
    wait_n(n0 + 2, 9000);
    `CHK(got_n, n0 + 1)
    wait_n(n0 + 2, 2000);
    `CHK(got_n, n0 + 2)
    od(1'b1, 16'h1801, 8'h05, 32'h00000000);
  endtask
  task automatic s_sync;
    od(1'b1, 16'h1802, 8'h02, 32'h00000001);
    od(1'b1, 16'h1802, 8'h06, 32'h00000005);
    n0 = got_n;
    ev(2'h0, 1'b1, 8'h03);
    ev(2'h0, 1'b1, 8'h04);
    wait_n(n0 + 2, 20);
    `CHK(got_n, n0 + 2)
    `CHK(got_id, 32'hA5A55A5A)
    pulse(save_req_i);
    od(1'b1, 16'h1802, 8'h04, 32'h00000077);
    pulse(restart_i);
    od(1'b0, 16'h1802, 8'h04, 32'h00000000);
    `CHK(rd, 32'h00000000)
    sync_overflow_i = 8'h02;
    n0 = got_n;
    ev(2'h0, 1'b1, 8'h03);
    wait_n(n0 + 1, 20);
    `CHK(got_n, n0)
    ev(2'h0, 1'b1, 8'h05);
    ev(2'h0, 1'b1, 8'h06);
    wait_n(n0 + 2, 20);
    `CHK(got_n, n0 + 2)
    stall = 1'b1;
    n0 = got_n;
    repeat (40) ev(2'h0, 1'b1, 8'h07);
    stall = 1'b0;
    wait_n(n0 + 40, 200);
    `CHK((got_n - n0) inside {[32:34]}, 1'b1)
    `CHK(frame_valid_o, 1'b0)
    od(1'b1, 16'h1801, 8'h02, 32'h00000000);
    n0 = got_n;
    ev(2'h1, 1'b0, 8'h00);
    wait_n(n0 + 1, 20);
    `CHK(got_n, n0)
    ev(2'h0, 1'b1, 8'h08);
    wait_n(n0 + 2, 20);
    `CHK(got_n, n0 + 2)
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    s_defaults;
    s_access;
    s_inhibit;
    s_timer;
    s_sync;
    summarize;
  end
  initial
  begin
    repeat (90000) @(posedge core_clk_i);
    n_fail++;
    summarize;
  end
endmodule
bind tx_pdo_comm_param_scheduler tx_pdo_sched_chk #(.DATA_W(DATA_W)) chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .od_req_i(od_req_i),
  .od_wr_i(od_wr_i), .od_index_i(od_index_i), .od_sub_i(od_sub_i),
  .od_wdata_i(od_wdata_i), .od_ack_o(od_ack_o), .od_abort_o(od_abort_o),
  .od_rdata_o(od_rdata_o), .frame_valid_o(frame_valid_o),
  .frame_ready_i(frame_ready_i), .frame_id_o(frame_id_o),
  .frame_data_o(frame_data_o));
`default_nettype wire

// ---- sim/tx_pdo_sched_chk_sva.sv ----
// assertions on the scheduler's access and frame ports
`timescale 1ns/100ps
`default_nettype none
module tx_pdo_sched_chk #(
  parameter DATA_W = 64
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // object access
  input wire logic od_req_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_sub_i,
  input wire logic [31:0] od_wdata_i,
  input wire logic od_ack_o,
  input wire logic od_abort_o,
  input wire logic [31:0] od_rdata_o,
  // frames
  input wire logic frame_valid_o,
  input wire logic frame_ready_i,
  input wire logic [31:0] frame_id_o,
  input wire logic [DATA_W-1:0] frame_data_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_wr_rd(logic [7:0] s);
    od_req_i && od_wr_i && od_sub_i == s &&
      od_index_i inside {16'h1801, 16'h1802} ##2
      od_req_i && !od_wr_i && od_sub_i == s &&
      od_index_i == $past(od_index_i, 2);
  endsequence
  property p_count_rd;
    od_req_i && !od_wr_i && od_sub_i == 8'h00 &&
      od_index_i inside {16'h1801, 16'h1802, 16'h1803}
      |=> !od_abort_o && od_rdata_o == 32'h00000006;
  endproperty
  a_count_rd: assert property (p_count_rd) else $error("bad count");
  property p_count_ro;
    od_req_i && od_wr_i && od_sub_i == 8'h00 |=> od_ack_o && od_abort_o;
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count taken");
  property p_tx4_sub;
    od_req_i && od_index_i == 16'h1803 && od_sub_i != 8'h00 |=> od_abort_o;
  endproperty
  a_tx4_sub: assert property (p_tx4_sub) else $error("sub accepted");
  property p_ack;
    od_req_i |=> od_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_no_ack;
    !od_req_i |=> !od_ack_o && !od_abort_o;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray answer");
  property p_ident_back;
    s_wr_rd(8'h01) |=> od_rdata_o == $past(od_wdata_i, 3) && !od_abort_o;
  endproperty
  a_ident_back: assert property (p_ident_back) else $error("ident lost");
  property p_place_back;
    s_wr_rd(8'h04) |=>
      od_rdata_o == {24'h000000, $past(od_wdata_i[7:0], 3)};
  endproperty
  a_place_back: assert property (p_place_back) else $error("place lost");
  property p_hold;
    frame_valid_o && !frame_ready_i |=> frame_valid_o &&
      $stable(frame_id_o) && $stable(frame_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("frame dropped");
endmodule
`default_nettype wire
